// File: rtl/srpace_port.v
// Serial remote port: receiver, 256-character buffer, receive pacing, transmitter.
// Assumes switches and rxd are asynchronous pins; the command parser sits outside.
`timescale 1ns/1ps
`include "srpace_map.vh"
module srpace_port
#(
  parameter CLK_HZ = `SRP_CLK_HZ,
  parameter REPLY_DELAY = (CLK_HZ / 1000) * `SRP_REPLY_DELAY_MS
)
(
  input wire clk_sys, // System clock
  input wire reset, // Synchronous reset, high
  input wire [6:0] switches, // Rear switches, 1 = up, bit0 = switch one
  input wire rxd, // Serial receive pin
  output reg txd, // Serial transmit pin
  output reg rts, // Request to send, 1 = true
  output reg dtr, // Data terminal ready, 1 = true
  output reg [6:0] rx_data, // Received character, 7-bit
  output reg rx_valid, // Received character valid
  input wire rx_ready, // Consumer takes character
  input wire [7:0] reply_data, // Reply character from parser
  input wire reply_valid, // Reply character offered
  output reg reply_ready, // Reply character accepted
  input wire reply_query, // Pulse: query received, start reply delay
  input wire reply_last, // Marks last reply character, CR LF follow
  input wire cmd_local, // Pulse: return to local command decoded
  input wire cmd_remote, // Pulse: go remote command decoded
  input wire cmd_enh_set, // Pulse: enhancements command
  input wire cmd_enh_val, // Value for enhancements command
  input wire local_key, // Front-panel local key level
  input wire local_lockout, // Local lockout in effect
  output reg remote_led, // Remote indicator
  output reg enh_mode, // Enhancements mode on
  output reg restore_last, // Power-on uses last turn-off state
  output reg [12:0] baud_show, // Baud rate for the display
  output reg baud_changed // One pulse when baud setting changes
);
  // Switch synchroniser: three stages, change accepted when last two agree
  reg [6:0] sw_s1_reg, sw_s2_reg, sw_s3_reg, sw_reg;
  reg [2:0] rx_s_reg;
  reg rx_pin_reg;
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      sw_s1_reg <= 7'h7F;
      sw_s2_reg <= 7'h7F;
      sw_s3_reg <= 7'h7F;
      sw_reg <= 7'h7F;
      rx_s_reg <= 3'h7;
      rx_pin_reg <= 1'b1;
    end
    else
    begin
      sw_s1_reg <= switches;
      sw_s2_reg <= sw_s1_reg;
      sw_s3_reg <= sw_s2_reg;
      if (sw_s2_reg == sw_s3_reg)
        sw_reg <= sw_s3_reg;
      rx_s_reg <= {rx_s_reg[1:0], rxd};
      if (rx_s_reg[1] == rx_s_reg[2])
        rx_pin_reg <= rx_s_reg[2];
    end
  end

  // Oversample tick, sixteen per bit
  function [19:0] div16;
    input [1:0] sel;
    reg [31:0] q;
    begin
      case (sel)
        2'h3: q = CLK_HZ / (16 * `SRP_BAUD_300);
        2'h2: q = CLK_HZ / (16 * `SRP_BAUD_1200);
        2'h1: q = CLK_HZ / (16 * `SRP_BAUD_2400);
        default: q = CLK_HZ / (16 * `SRP_BAUD_4800);
      endcase
      div16 = q[19:0];
    end
  endfunction
  wire [1:0] baud_sel = {sw_reg[`SRP_SW_BAUD0], sw_reg[`SRP_SW_BAUD1]};
  reg [19:0] tick_cnt_reg;
  reg tick_reg;
  reg [1:0] baud_last_reg;
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      tick_cnt_reg <= 20'h00000;
      tick_reg <= 1'b0;
      baud_last_reg <= 2'h3;
      baud_show <= 13'h012C;
      baud_changed <= 1'b0;
    end
    else
    begin
      tick_reg <= (tick_cnt_reg == 20'h00000);
      if (tick_cnt_reg == 20'h00000)
        tick_cnt_reg <= div16(baud_sel) - 20'h00001;
      else
        tick_cnt_reg <= tick_cnt_reg - 20'h00001;
      baud_last_reg <= baud_sel;
      baud_changed <= (baud_last_reg != baud_sel);
      case (baud_sel)
        2'h3: baud_show <= 13'h012C;
        2'h2: baud_show <= 13'h04B0;
        2'h1: baud_show <= 13'h0960;
        default: baud_show <= 13'h12C0;
      endcase
    end
  end

  // Receiver: start, 7 data bits, parity bit or eighth bit, stop
  reg [3:0] rx_ph_reg;
  reg [3:0] rx_bit_reg;
  reg [7:0] rx_sh_reg;
  reg rx_busy_reg;
  reg rx_done_reg;
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      rx_ph_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_busy_reg <= 1'b0;
      rx_done_reg <= 1'b0;
    end
    else
    begin
      rx_done_reg <= 1'b0;
      if (tick_reg)
      begin
        if (!rx_busy_reg)
        begin
          if (!rx_pin_reg)
          begin
            rx_busy_reg <= 1'b1;
            rx_ph_reg <= 4'h8;
            rx_bit_reg <= 4'h0;
          end
        end
        else
        begin
          rx_ph_reg <= rx_ph_reg + 4'h1;
          if (rx_ph_reg == 4'hF)
          begin
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == 4'h0 && rx_pin_reg)
              rx_busy_reg <= 1'b0;
            else if (rx_bit_reg == 4'h9)
            begin
              rx_busy_reg <= 1'b0;
              rx_done_reg <= rx_pin_reg;
            end
            else if (rx_bit_reg != 4'h0)
              rx_sh_reg <= {rx_pin_reg, rx_sh_reg[7:1]};
          end
        end
      end
    end
  end

  // Receive buffer, 256 deep
  reg [6:0] buf_mem [0:`SRP_BUF_DEPTH-1];
  reg [7:0] wr_ptr_reg, rd_ptr_reg;
  reg [8:0] count_reg;
  localparam [8:0] BUF_DEPTH9 = `SRP_BUF_DEPTH;
  wire buf_full = (count_reg == BUF_DEPTH9);
  wire buf_push = rx_done_reg & ~buf_full;
  wire skid_take = ~rx_valid | rx_ready;
  wire buf_pop = (count_reg != 9'h000) & skid_take;
  wire [8:0] free_room = BUF_DEPTH9 - count_reg;
  always @(posedge clk_sys)
  begin
    if (buf_push)
      buf_mem[wr_ptr_reg] <= rx_sh_reg[6:0];
  end
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_ptr_reg <= 8'h00;
      rd_ptr_reg <= 8'h00;
      count_reg <= 9'h000;
      rx_valid <= 1'b0;
      rx_data <= 7'h00;
      remote_led <= 1'b0;
    end
    else
    begin
      if (buf_push)
        wr_ptr_reg <= wr_ptr_reg + 8'h01;
      if (buf_pop)
        rd_ptr_reg <= rd_ptr_reg + 8'h01;
      count_reg <= count_reg + {8'h00, buf_push} - {8'h00, buf_pop};
      if (buf_pop)
      begin
        rx_data <= buf_mem[rd_ptr_reg];
        rx_valid <= 1'b1;
      end
      else if (rx_ready)
        rx_valid <= 1'b0;
      // Mode changes touch no operating state
      if (buf_push || cmd_remote)
        remote_led <= 1'b1;
      else if (cmd_local || (local_key && !local_lockout))
        remote_led <= 1'b0;
    end
  end

  // Pacing
  wire soft_pace = sw_reg[`SRP_SW_PACE];
  wire low_room = (free_room < `SRP_LOW_ROOM);
  wire all_free = (count_reg == 9'h000);
  wire tx_take_stop;
  wire tx_take_go;
  reg paused_reg, stop_due_reg, go_due_reg;
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      paused_reg <= 1'b0;
      stop_due_reg <= 1'b0;
      go_due_reg <= 1'b0;
      rts <= 1'b1;
      dtr <= 1'b1;
    end
    else
    begin
      // New pacing request wins over the transmitter's clear
      if (tx_take_stop)
        stop_due_reg <= 1'b0;
      if (tx_take_go)
        go_due_reg <= 1'b0;
      if (!paused_reg && low_room)
      begin
        paused_reg <= 1'b1;
        stop_due_reg <= soft_pace;
        go_due_reg <= 1'b0;
      end
      else if (paused_reg && all_free)
      begin
        paused_reg <= 1'b0;
        go_due_reg <= soft_pace;
      end
      rts <= soft_pace | ~paused_reg;
      dtr <= soft_pace | ~paused_reg;
    end
  end

  // Two-entry buffer in the reply path
  reg [7:0] sk_data_reg [0:1];
  reg [1:0] sk_last_reg;
  reg [1:0] sk_cnt_reg;
  reg sk_rd_reg, sk_wr_reg;
  wire sk_in = reply_valid & reply_ready;
  wire sk_out;
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      sk_cnt_reg <= 2'h0;
      sk_rd_reg <= 1'b0;
      sk_wr_reg <= 1'b0;
      reply_ready <= 1'b0;
      sk_last_reg <= 2'h0;
    end
    else
    begin
      if (sk_in)
      begin
        sk_data_reg[sk_wr_reg] <= reply_data;
        sk_last_reg[sk_wr_reg] <= reply_last;
        sk_wr_reg <= ~sk_wr_reg;
      end
      if (sk_out)
        sk_rd_reg <= ~sk_rd_reg;
      sk_cnt_reg <= sk_cnt_reg + {1'b0, sk_in} - {1'b0, sk_out};
      reply_ready <= (sk_cnt_reg + {1'b0, sk_in} - {1'b0, sk_out}) < 2'h2;
    end
  end

  // Transmitter: pacing codes first, then delayed reply bytes and CR LF
  localparam TX_IDLE = 3'h1;
  localparam TX_SEND = 3'h2;
  localparam TX_WAIT = 3'h4;
  reg [2:0] tx_st_reg;
  reg [10:0] tx_sh_reg;
  reg [3:0] tx_ph_reg, tx_bits_reg;
  reg [31:0] dly_reg;
  reg [1:0] tail_reg;
  wire reply_ok = (dly_reg == 32'h00000000);
  wire tx_idle = (tx_st_reg == TX_IDLE);
  assign tx_take_stop = tx_idle & stop_due_reg;
  assign tx_take_go = tx_idle & ~stop_due_reg & go_due_reg;
  wire tx_take_tail = tx_idle & ~stop_due_reg & ~go_due_reg & (tail_reg != 2'h0);
  assign sk_out = tx_idle & ~stop_due_reg & ~go_due_reg & (tail_reg == 2'h0)
    & reply_ok & (sk_cnt_reg != 2'h0);

  // Frame builder: start, data, parity or eighth bit, stop
  function [10:0] frame;
    input [7:0] ch;
    input [6:0] sw;
    reg p;
    begin
      p = 1'b0;
      if (sw[`SRP_SW_WORD])
        p = ^ch[6:0] ^ ~sw[`SRP_SW_PARITY];
      else if (sw[`SRP_SW_PARITY])
        p = ch[7];
      frame = {1'b1, 1'b1, p, ch[6:0], 1'b0};
    end
  endfunction
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      tx_st_reg <= TX_IDLE;
      tx_sh_reg <= 11'h7FF;
      tx_ph_reg <= 4'h0;
      tx_bits_reg <= 4'h0;
      dly_reg <= 32'h00000000;
      tail_reg <= 2'h0;
      txd <= 1'b1;
    end
    else
    begin
      if (reply_query)
        dly_reg <= REPLY_DELAY;
      else if (dly_reg != 32'h00000000)
        dly_reg <= dly_reg - 32'h00000001;
      case (tx_st_reg)
        TX_IDLE:
        begin
          txd <= 1'b1;
          if (tx_take_stop || tx_take_go || tx_take_tail || sk_out)
          begin
            tx_st_reg <= TX_WAIT;
            tx_bits_reg <= 4'hA;
            if (tx_take_stop)
              tx_sh_reg <= frame(`SRP_CHAR_STOP, sw_reg);
            else if (tx_take_go)
              tx_sh_reg <= frame(`SRP_CHAR_RESUME, sw_reg);
            else if (tx_take_tail)
            begin
              tx_sh_reg <= frame((tail_reg == 2'h2) ? `SRP_CHAR_CR : `SRP_CHAR_LF, sw_reg);
              tail_reg <= tail_reg - 2'h1;
            end
            else
            begin
              tx_sh_reg <= frame(sk_data_reg[sk_rd_reg], sw_reg);
              if (sk_last_reg[sk_rd_reg])
                tail_reg <= 2'h2;
            end
          end
        end
        TX_WAIT:
          if (tick_reg)
          begin
            tx_st_reg <= TX_SEND;
            tx_ph_reg <= 4'h0;
          end
        TX_SEND:
        begin
          txd <= tx_sh_reg[0];
          if (tick_reg)
          begin
            tx_ph_reg <= tx_ph_reg + 4'h1;
            if (tx_ph_reg == 4'hF)
            begin
              tx_sh_reg <= {1'b1, tx_sh_reg[10:1]};
              tx_bits_reg <= tx_bits_reg - 4'h1;
              if (tx_bits_reg == 4'h1)
                tx_st_reg <= TX_IDLE;
            end
          end
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  // Enhancements and power-on choice; no transmit halt input exists
  always @(posedge clk_sys)
  begin
    if (reset)
    begin
      enh_mode <= 1'b1;
      restore_last <= 1'b0;
    end
    else
    begin
      if (cmd_enh_set)
        enh_mode <= cmd_enh_val;
      else if (sw_reg[`SRP_SW_ENH] != sw_s3_reg[`SRP_SW_ENH] && sw_s2_reg == sw_s3_reg)
        enh_mode <= sw_s3_reg[`SRP_SW_ENH];
      restore_last <= ~sw_reg[`SRP_SW_PRESET] & enh_mode;
    end
  end
endmodule

// File: rtl/srpace_map.vh
// Constants for the serial remote port with receive pacing.
// Assumes a 250 MHz system clock; included by the port module only.
`ifndef SRPACE_MAP_VH
`define SRPACE_MAP_VH
`define SRP_CLK_HZ 250000000
`define SRP_BAUD_300 300
`define SRP_BAUD_1200 1200
`define SRP_BAUD_2400 2400
`define SRP_BAUD_4800 4800
`define SRP_BUF_DEPTH 256
`define SRP_LOW_ROOM 128
`define SRP_CHAR_STOP 8'h13
`define SRP_CHAR_RESUME 8'h11
`define SRP_CHAR_CR 8'h0D
`define SRP_CHAR_LF 8'h0A
`define SRP_REPLY_DELAY_MS 100
`define SRP_SW_BAUD0 2
`define SRP_SW_BAUD1 3
`define SRP_SW_WORD 4
`define SRP_SW_PARITY 5
`define SRP_SW_PACE 6
`define SRP_SW_ENH 0
`define SRP_SW_PRESET 1
`endif

// File: tb/srpace_sva.sv
// Checker for srpace_port, bound from the bench top.
// Assumes switches are held for many cycles between changes.
`timescale 1ns/1ps
module srpace_sva
(
  input wire clk_sys, // Clock
  input wire reset, // Reset
  input wire [6:0] switches, // Switches
  input wire rts, // Pacing out
  input wire dtr, // Pacing out
  input wire rx_valid, // Char valid
  input wire rx_ready, // Char taken
  input wire [6:0] rx_data, // Char
  input wire cmd_local, // Local cmd
  input wire cmd_remote, // Remote cmd
  input wire cmd_enh_set, // Enh cmd
  input wire cmd_enh_val, // Enh value
  input wire local_lockout, // Lockout
  input wire remote_led, // Remote
  input wire enh_mode, // Enh mode
  input wire restore_last, // Restore
  input wire [12:0] baud_show // Baud
);
  wire [12:0] baud_exp = switches[3] ? (switches[2] ? 13'h12C : 13'h960) : (switches[2] ? 13'h4B0 : 13'h12C0);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  sequence s_settled;
    $stable(switches)[*8];
  endsequence
  sequence s_soft;
    switches[6][*8];
  endsequence
  property p_baud;
    s_settled |-> baud_show == baud_exp;
  endproperty
  a_baud: assert property (p_baud) else $error("baud display wrong");
  property p_restore;
    $stable({switches, enh_mode})[*8] |-> restore_last == (!switches[1] && enh_mode);
  endproperty
  a_restore: assert property (p_restore) else $error("restore flag wrong");
  property p_pair;
    rts == dtr;
  endproperty
  a_pair: assert property (p_pair) else $error("rts and dtr differ");
  property p_soft;
    s_soft |-> rts;
  endproperty
  a_soft: assert property (p_soft) else $error("rts dropped in software pacing");
  property p_hold;
    rx_valid && !rx_ready |=> rx_valid && $stable(rx_data);
  endproperty
  a_hold: assert property (p_hold) else $error("received char lost");
  property p_enh;
    cmd_enh_set |=> enh_mode == $past(cmd_enh_val);
  endproperty
  a_enh: assert property (p_enh) else $error("enh command ignored");
  property p_remote;
    cmd_remote |=> remote_led;
  endproperty
  a_remote: assert property (p_remote) else $error("remote not entered");
  property p_lockout;
    local_lockout && remote_led && !cmd_local |=> remote_led;
  endproperty
  a_lockout: assert property (p_lockout) else $error("left remote under lockout");
endmodule

// File: tb/srpace_host.sv
// Host model: sends frames on rxd, decodes frames from txd.
// Assumes the same switches as the port; obeys pacing unless obey is cleared.
`timescale 1ns/1ps
module srpace_host
#(
  parameter CLK_HZ = 76800
)
(
  input wire clk_sys, // Clock
  input wire [6:0] switches, // Port switches
  input wire txd, // Port transmit
  input wire rts, // Port pacing
  input wire dtr, // Port pacing
  output reg rxd // Port receive
  // No service-request input
);
  reg paused = 1'b0;
  reg obey = 1'b1;
  reg [7:0] got [$];
  reg [7:0] f;
  integer blen;
  initial rxd = 1'b1;
  always_comb
    case (switches[3:2])
      2'h3: blen = CLK_HZ / 300;
      2'h1: blen = CLK_HZ / 1200;
      2'h2: blen = CLK_HZ / 2400;
      default: blen = CLK_HZ / 4800;
    endcase
  task send(input [7:0] ch);
    integer i;
  begin
    while (obey && (paused || !(rts && dtr))) @(posedge clk_sys);
    for (i = 0; i < 10; i = i + 1)
    begin
      case (i)
        0: rxd <= 1'b0;
        8: rxd <= switches[4] ? ^ch[6:0] ^ ~switches[5] : ch[7] & switches[5];
        9: rxd <= 1'b1;
        default: rxd <= ch[i - 1];
      endcase
      repeat (blen) @(posedge clk_sys);
    end
  end
  endtask
  initial forever
  begin
    @(negedge txd);
    repeat (blen / 2) @(posedge clk_sys);
    repeat (8)
    begin
      repeat (blen) @(posedge clk_sys);
      f = {txd, f[7:1]};
    end
    repeat (blen) @(posedge clk_sys);
    got.push_back(f);
    if (f[6:0] == 7'h13) paused = 1'b1;
    if (f[6:0] == 7'h11) paused = 1'b0;
  end
endmodule

// File: tb/serial_remote_port_with_receive_pacing_test.sv
// Bench for srpace_port: switch table, remote control, both pacing modes.
// Assumes the host model srpace_host and the checker srpace_sva.
`timescale 1ns/1ps
module serial_remote_port_with_receive_pacing_test;
  localparam HZ = 76800;
  reg clk_sys = 1'b0;
  reg reset = 1'b1;
  reg [6:0] switches = 7'h7F;
  reg rx_ready = 1'b0;
  reg [7:0] reply_data = 8'h00;
  reg reply_valid = 1'b0, reply_query = 1'b0, reply_last = 1'b0;
  reg cmd_local = 1'b0, cmd_remote = 1'b0, cmd_enh_set = 1'b0, cmd_enh_val = 1'b0;
  reg local_key = 1'b0, local_lockout = 1'b0;
  wire rxd, txd, rts, dtr, rx_valid, reply_ready, remote_led, enh_mode, restore_last, baud_changed;
  wire [6:0] rx_data;
  wire [12:0] baud_show;
  reg [53:0] rows [0:3];
  reg [53:0] row;
  integer bad_count = 0, total_checks = 0, r, n, k;
  srpace_port #(.CLK_HZ(HZ), .REPLY_DELAY(100)) srpace_port_i (
    .clk_sys(clk_sys), .reset(reset), .switches(switches), .rxd(rxd), .txd(txd), .rts(rts), .dtr(dtr),
    .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .reply_data(reply_data),
    .reply_valid(reply_valid), .reply_ready(reply_ready), .reply_query(reply_query), .reply_last(reply_last),
    .cmd_local(cmd_local), .cmd_remote(cmd_remote), .cmd_enh_set(cmd_enh_set), .cmd_enh_val(cmd_enh_val),
    .local_key(local_key), .local_lockout(local_lockout), .remote_led(remote_led), .enh_mode(enh_mode),
    .restore_last(restore_last), .baud_show(baud_show), .baud_changed(baud_changed)
  );
  srpace_host #(.CLK_HZ(HZ)) srpace_host_i (
    .clk_sys(clk_sys), .switches(switches), .txd(txd), .rts(rts), .dtr(dtr), .rxd(rxd)
  );
  always #2 clk_sys = ~clk_sys;
  task tick(input integer c);
    repeat (c) @(posedge clk_sys);
  endtask
  task check(input [12:0] v, input [12:0] e);
  begin
    total_checks = total_checks + 1;
    if (v !== e)
    begin
      bad_count = bad_count + 1;
      $display("wrong value at %0t: got %h expected %h", $time, v, e);
    end
  end
  endtask
  task strobe(input [1:0] w);
  begin
    {cmd_enh_set, cmd_remote, cmd_local} <= 3'h1 << w;
    tick(1);
    {cmd_enh_set, cmd_remote, cmd_local} <= 3'h0;
    tick(2);
  end
  endtask
  task drain(input integer c);
  begin
    k = 0;
    rx_ready <= 1'b1;
    repeat (c)
    begin
      tick(1);
      if (rx_valid === 1'b1) k = k + 1;
    end
    rx_ready <= 1'b0;
  end
  endtask
  task results;
  begin
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  end
  endtask
  initial
  begin
    #360000;
    bad_count = bad_count + 1;
    results;
  end
  initial
  begin
    // Switches, baud shown, reply char, three frames on txd, enh, restore
    rows[0] = {7'h7F, 13'h12C, 8'h43, 24'hC38D0A, 2'h2};
    rows[1] = {7'h55, 13'h4B0, 8'h43, 24'h430D8A, 2'h3};
    rows[2] = {7'h68, 13'h960, 8'hC3, 24'hC30D0A, 2'h0};
    rows[3] = {7'h43, 13'h12C0, 8'hC3, 24'h430D0A, 2'h2};
    tick(4);
    reset <= 1'b0;
    tick(1);
    check({txd, rts, dtr, rx_valid, remote_led, enh_mode, restore_last}, 7'h72);
    check(baud_show, 13'h12C);
    tick(4);
    for (r = 0; r < 4; r = r + 1)
    begin
      row = rows[r];
      switches <= row[53:47];
      k = 0;
      repeat (8)
      begin
        tick(1);
        if (baud_changed === 1'b1) k = k + 1;
      end
      check(k, r != 0);
      check(baud_show, row[46:34]);
      check(enh_mode, row[1]);
      check(restore_last, row[0]);
      srpace_host_i.send(8'h93);
      tick(8);
      check(rx_data, 7'h13);
      check(remote_led, 1'b1);
      drain(2);
      check(k, 1);
      reply_query <= 1'b1;
      tick(1);
      reply_query <= 1'b0;
      reply_data <= row[33:26];
      reply_valid <= 1'b1;
      reply_last <= 1'b1;
      tick(1);
      while (reply_ready !== 1'b1) tick(1);
      reply_valid <= 1'b0;
      n = 0;
      while (srpace_host_i.got.size() < 3 && n < 40000)
      begin
        tick(1);
        n = n + 1;
      end
      check(srpace_host_i.got[0], row[25:18]);
      check(srpace_host_i.got[1], row[17:10]);
      check(srpace_host_i.got[2], row[9:2]);
      srpace_host_i.got.delete();
    end
    strobe(0);
    check(remote_led, 1'b0);
    strobe(1);
    check(remote_led, 1'b1);
    local_lockout <= 1'b1;
    local_key <= 1'b1;
    tick(8);
    check(remote_led, 1'b1);
    local_lockout <= 1'b0;
    tick(8);
    check(remote_led, 1'b0);
    local_key <= 1'b0;
    switches <= 7'h41;
    strobe(2);
    tick(8);
    check({enh_mode, restore_last}, 2'h0);
    cmd_enh_val <= 1'b1;
    strobe(2);
    check({enh_mode, restore_last}, 2'h3);
    n = 0;
    while (srpace_host_i.got.size() == 0 && n < 200)
    begin
      srpace_host_i.send(8'h30);
      n = n + 1;
    end
    check(srpace_host_i.got[0], 8'h13);
    check(n > 128 && n < 133, 1'b1);
    check(rts, 1'b1);
    drain(1200);
    check(k, n);
    check(srpace_host_i.got[1], 8'h11);
    switches <= 7'h01;
    srpace_host_i.obey = 1'b0;
    srpace_host_i.got.delete();
    tick(8);
    for (n = 0; n < 258; n = n + 1)
    begin
      srpace_host_i.send(n[7:0]);
      if (n == 130) check(rts, 1'b0);
    end
    drain(800);
    // Full buffer plus the output slot; the last arrival is dropped
    check(k, 257);
    check(rts, 1'b1);
    check(srpace_host_i.got.size(), 0);
    results;
  end
endmodule
bind srpace_port srpace_sva srpace_sva_i (
  .clk_sys(clk_sys), .reset(reset), .switches(switches), .rts(rts), .dtr(dtr), .rx_valid(rx_valid),
  .rx_ready(rx_ready), .rx_data(rx_data), .cmd_local(cmd_local), .cmd_remote(cmd_remote),
  .cmd_enh_set(cmd_enh_set), .cmd_enh_val(cmd_enh_val), .local_lockout(local_lockout),
  .remote_led(remote_led), .enh_mode(enh_mode), .restore_last(restore_last), .baud_show(baud_show)
);
